//--- shared/sfrid_pkg.sv
// Purpose: constants for the special-register space decoder and identification bytes
// Assumes: 8-bit direct address from the core, one access per strobe
// Notes: identification values live as module parameters of the top

`default_nettype none

package sfrid_pkg;
    localparam logic [7:0] SPC_BASE = 8'h80;            // first special-register address
    localparam logic [7:0] VARIANT_CODE_ADDR = 8'had;
    localparam logic [7:0] FAMILY_CODE_ADDR = 8'hb5;
    localparam logic [7:0] STEPPING_CODE_ADDR = 8'hb6;
    localparam logic [2:0] BIT_ADDR_NIBBLE_LSBS = 3'h0; // low three bits of bit-addressable row
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam int READ_LATENCY = 1;                    // cycles from strobe to read data
endpackage : sfrid_pkg

`default_nettype wire

//--- design/sfrid_top.sv
// Purpose: special-register space decode with three read-only identification bytes
// Assumes: core presents address, mode and strobes synchronous to i_mclk
// Notes: registers other than the identification bytes are decoded but not implemented here
// Notes: the select flags tell the surrounding system where an access is routed; the
//        peripheral registers themselves live elsewhere and answer on their own
// Notes: all outputs are registered, so every answer lands exactly one enabled edge
//        after the access is taken
//
// How it works
// - three read-only bytes give family, variant and stepping identification to firmware.
// - family code byte sits at 0xb5, all eight bits fixed.
// - variant code byte sits at 0xad, one value per derivative fitted.
// - stepping code byte sits at 0xb6, value names the silicon revision.
// - direct accesses at 0x80 through 0xff go to the special-register space.
// - addresses ending in 0x0 or 0x8 also allow single-bit reads and writes.
// - every other special register allows whole-byte access only.
// - indirect accesses above 0x7f reach upper data memory, not special registers.

`timescale 1ns/1ps
`default_nettype none

module sfrid_top #(
    parameter logic [7:0] FAMILY_CODE = 8'h5a,    // arbitrary value
    parameter logic [7:0] VARIANT_CODE = 8'h3c,   // arbitrary value
    parameter logic [7:0] STEPPING_CODE = 8'h01   // arbitrary value
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic i_indirect,
    input wire logic i_bit_op,
    input wire logic [2:0] i_bit_sel,
    input wire logic i_rd,
    input wire logic i_wr,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_spc_sel,
    output logic o_ram_sel,
    output logic o_bit_ok,
    output logic o_id_hit
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // special space only for direct addressing with the top bit set
    function automatic logic sfrid_is_spc(input logic [7:0] a, input logic ind);
        sfrid_is_spc = (a >= sfrid_pkg::SPC_BASE) && !ind;
    endfunction : sfrid_is_spc

    function automatic logic sfrid_bit_capable(input logic [7:0] a);
        sfrid_bit_capable = (a[2:0] == sfrid_pkg::BIT_ADDR_NIBBLE_LSBS);
    endfunction : sfrid_bit_capable

    logic acc;
    logic spc_hit;
    logic bit_legal;
    logic [7:0] id_byte;
    logic id_match;

    assign acc = i_ce && (i_rd || i_wr);
    assign spc_hit = sfrid_is_spc(i_addr, i_indirect);
    assign bit_legal = !i_bit_op || sfrid_bit_capable(i_addr);

    // identification byte lookup, writes never reach these values
    always_comb begin
        id_match = 1'b1;
        case (i_addr)
            sfrid_pkg::FAMILY_CODE_ADDR: id_byte = FAMILY_CODE;
            sfrid_pkg::VARIANT_CODE_ADDR: id_byte = VARIANT_CODE;
            sfrid_pkg::STEPPING_CODE_ADDR: id_byte = STEPPING_CODE;
            default: begin
                id_byte = 8'h00;
                id_match = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // routing flags, registered so outputs come from flops
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_spc_sel <= 1'b0;
            o_ram_sel <= 1'b0;
            o_bit_ok <= 1'b0;
            o_id_hit <= 1'b0;
        end else if (i_ce) begin
            o_spc_sel <= acc && spc_hit;
            o_ram_sel <= acc && !spc_hit;
            o_bit_ok <= acc && spc_hit && bit_legal;
            o_id_hit <= acc && spc_hit && id_match;
        end
    end

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    // bit reads return the chosen bit in bit 0; a write is simply dropped,
    // which keeps the codes fixed without any error path
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_rdata <= sfrid_pkg::RDATA_RESET;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_rvalid <= i_rd && !i_wr && spc_hit && id_match && bit_legal;
            if (i_rd && !i_wr && spc_hit && id_match && bit_legal) begin
                if (i_bit_op) begin
                    o_rdata <= {7'h00, id_byte[i_bit_sel]};
                end else begin
                    o_rdata <= id_byte;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    family_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_rd && !i_wr && !i_indirect && !i_bit_op
         && i_addr == sfrid_pkg::FAMILY_CODE_ADDR) |=> (o_rvalid && o_rdata == FAMILY_CODE))
        else $error("family code read wrong");
    variant_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_rd && !i_wr && !i_indirect && !i_bit_op
         && i_addr == sfrid_pkg::VARIANT_CODE_ADDR) |=> (o_rvalid && o_rdata == VARIANT_CODE))
        else $error("variant code read wrong");
    stepping_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_rd && !i_wr && !i_indirect && !i_bit_op
         && i_addr == sfrid_pkg::STEPPING_CODE_ADDR) |=> (o_rvalid && o_rdata == STEPPING_CODE))
        else $error("stepping code read wrong");
    direct_route_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_rd && !i_indirect && i_addr[7]) |=> (o_spc_sel && !o_ram_sel))
        else $error("direct upper access not routed to special space");
    indirect_route_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_rd && i_indirect) |=> (o_ram_sel && !o_spc_sel && !o_rvalid))
        else $error("indirect access reached special space");
    bit_allowed_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_rd && !i_indirect && i_bit_op && i_addr[7] && i_addr[2:0] == 3'h0)
        |=> o_bit_ok)
        else $error("bit access refused on bit-capable address");
    bit_refused_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_rd && i_bit_op && i_addr[2:0] != 3'h0) |=> (!o_bit_ok && !o_rvalid))
        else $error("bit access accepted on byte-only address");
    write_ignored_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_wr && !i_indirect && i_addr == sfrid_pkg::FAMILY_CODE_ADDR)
        ##1 (i_ce && i_rd && !i_wr && !i_indirect && !i_bit_op
             && i_addr == sfrid_pkg::FAMILY_CODE_ADDR) |=> (o_rdata == FAMILY_CODE))
        else $error("identification byte changed by a write");
    hold_freeze_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !i_ce |=> $stable(o_rdata) && $stable(o_rvalid))
        else $error("state changed with clock enable low");

    // ------------------------------------------------------------
    // routing and refusal checks
    // ------------------------------------------------------------
    // direct accesses below the special space belong to data memory
    low_direct_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && (i_rd || i_wr) && !i_indirect && !i_addr[7])
        |=> (o_ram_sel && !o_spc_sel && !o_id_hit))
        else $error("low direct access not routed to data memory");

    // any direct access to an id address raises the hit flag, read or write
    id_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && (i_rd || i_wr) && !i_indirect
         && (i_addr == sfrid_pkg::FAMILY_CODE_ADDR || i_addr == sfrid_pkg::VARIANT_CODE_ADDR
             || i_addr == sfrid_pkg::STEPPING_CODE_ADDR)) |=> o_id_hit)
        else $error("identification hit flag missing");

    // reserved and foreign special addresses give no data from this block
    reserved_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_rd && !i_indirect && i_addr[7]
         && i_addr != sfrid_pkg::FAMILY_CODE_ADDR && i_addr != sfrid_pkg::VARIANT_CODE_ADDR
         && i_addr != sfrid_pkg::STEPPING_CODE_ADDR) |=> (!o_rvalid && !o_id_hit))
        else $error("data returned for a non-identification address");

    // a write never produces read data, so nothing looks like an error reply
    write_no_data_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_wr) |=> !o_rvalid)
        else $error("read data pulse after a write");

    // a write to an id byte is still routed and flagged, just dropped
    id_write_hit_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && i_wr && !i_rd && !i_indirect && i_addr == sfrid_pkg::STEPPING_CODE_ADDR)
        |=> (o_spc_sel && o_id_hit && !o_rvalid))
        else $error("identification write not routed as expected");

    // read data only moves on a direct upper read; anything else leaves it alone
    rdata_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && !(i_rd && !i_wr && !i_indirect && i_addr[7])) |=> $stable(o_rdata))
        else $error("read data changed without a read");

    // no strobe, no pulse: flags must fall back after one cycle
    idle_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && !i_rd && !i_wr)
        |=> (!o_spc_sel && !o_ram_sel && !o_bit_ok && !o_id_hit && !o_rvalid))
        else $error("flag pulse without an access");

    // a valid read can only come from an identification hit in special space
    rvalid_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_rvalid |-> (o_id_hit && o_spc_sel && !o_ram_sel))
        else $error("read data pulse without an identification hit");

    // the two routes are exclusive, one access lands in one space only
    route_excl_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !(o_spc_sel && o_ram_sel))
        else $error("access routed to both spaces");

    id_read_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_rvalid && o_id_hit);
    ram_route_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_ram_sel);
    bit_read_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_ce && i_rd && i_bit_op && !i_indirect && i_addr == 8'hb0);
    id_write_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_ce && i_wr && !i_indirect && i_addr == sfrid_pkg::STEPPING_CODE_ADDR);

endmodule : sfrid_top

`default_nettype wire

//--- tb/sfrid_core_model.sv
// Purpose: core-side model issuing direct and indirect special-register accesses
// Assumes: one access per cycle, strobes last one clock
// Notes: the caller keeps to occupied addresses
`timescale 1ns/1ps
`default_nettype none
module sfrid_core_model (
    input wire logic i_mclk,
    output logic [7:0] o_addr,
    output logic o_indirect,
    output logic o_bit_op,
    output logic [2:0] o_bit_sel,
    output logic o_rd,
    output logic o_wr
);
    initial begin
        {o_addr, o_indirect, o_bit_op, o_bit_sel, o_rd, o_wr} = '0;
    end
    // everything changes just after an edge and holds for the whole cycle
    task automatic access(input logic [7:0] a, input logic ind, bop, rd, wr,
                          input logic [2:0] bs);
        @(posedge i_mclk);
        {o_addr, o_indirect, o_bit_op, o_bit_sel, o_rd, o_wr} <= {a, ind, bop, bs, rd, wr};
    endtask : access
    // released bus shows inverted address so a stale value cannot look valid
    task automatic idle();
        @(posedge i_mclk);
        {o_addr, o_rd, o_wr} <= {~o_addr, 2'b00};
    endtask : idle
endmodule : sfrid_core_model
`default_nettype wire

//--- tb/testbench.sv
// Purpose: self-checking bench for the special-register decoder and id bytes
// Assumes: core model drives requests, notes queue holds expected answers
// Notes: id values below are arbitrary
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] FAM = 8'h6e, VAR = 8'h47, STEP = 8'h02; // arbitrary values
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] addr, o_rdata, last_rd = sfrid_pkg::RDATA_RESET;
    logic ind, bop, rd, wr, o_rvalid, o_spc_sel, o_ram_sel, o_bit_ok, o_id_hit;
    logic ce = 1'b1;
    logic [2:0] bsel;
    logic [12:0] notes[$];
    logic [31:0] r;
    logic [7:0] ids[3] = '{8'hb5, 8'had, 8'hb6};
    int errors = 0, checked = 0, seed = 32'h9a5e;
    always #12.5 i_mclk = ~i_mclk;
    sfrid_core_model i_sfrid_core_model (.i_mclk(i_mclk), .o_addr(addr), .o_indirect(ind),
        .o_bit_op(bop), .o_bit_sel(bsel), .o_rd(rd), .o_wr(wr));
    sfrid_top #(.FAMILY_CODE(FAM), .VARIANT_CODE(VAR), .STEPPING_CODE(STEP)) i_sfrid_top (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(ce), .i_addr(addr), .i_indirect(ind),
        .i_bit_op(bop), .i_bit_sel(bsel), .i_rd(rd), .i_wr(wr), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_spc_sel(o_spc_sel), .o_ram_sel(o_ram_sel),
        .o_bit_ok(o_bit_ok), .o_id_hit(o_id_hit));
    task automatic chk(input logic [12:0] got, exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("counts: checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // note the expected answer, then hand the access to the core model
    task automatic req(input logic [7:0] a, input logic i, b, rw, input logic [2:0] s);
        logic ram, id, rv;
        ram = i | ~a[7];
        id = !ram && (a == sfrid_pkg::FAMILY_CODE_ADDR || a == sfrid_pkg::VARIANT_CODE_ADDR
            || a == sfrid_pkg::STEPPING_CODE_ADDR);
        rv = id && rw && !b;
        if (rv) last_rd = a == 8'hb5 ? FAM : (a == 8'had ? VAR : STEP);
        notes.push_back({rv, last_rd, !ram, ram, !ram && (!b || a[2:0] == 3'h0), id});
        i_sfrid_core_model.access(a, i, b, rw, !rw, s);
    endtask : req
    // watcher samples mid-cycle so the pulse launched at the edge has settled
    always @(negedge i_mclk) begin
        if (o_spc_sel === 1'b1 || o_ram_sel === 1'b1) begin
            chk({o_rvalid, o_rdata, o_spc_sel, o_ram_sel, o_bit_ok, o_id_hit},
                notes.size() ? notes.pop_front() : 13'h1fff);
        end
    end
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(negedge i_mclk);
        chk({o_rvalid, o_rdata, o_spc_sel, o_ram_sel, o_bit_ok, o_id_hit}, 13'h0);
        foreach (ids[k]) req(ids[k], 1'b0, 1'b0, 1'b1, 3'h0);
        foreach (ids[k]) req(ids[k], 1'b0, 1'b0, 1'b0, 3'h0);
        foreach (ids[k]) req(ids[k], 1'b0, 1'b1, 1'b1, 3'h2);
        req(8'hb5, 1'b1, 1'b0, 1'b1, 3'h0);
        req(8'h35, 1'b0, 1'b0, 1'b1, 3'h0);
        req(8'hb6, 1'b0, 1'b0, 1'b1, 3'h0);
        $display("test directed done");
        // release the bus first, then hold clock enable low so the freeze is exercised
        i_sfrid_core_model.idle();
        @(posedge i_mclk);
        ce <= 1'b0;
        repeat (3) @(posedge i_mclk);
        ce <= 1'b1;
        $display("test freeze done");
        // random mix stays on bit-capable rows and id bytes only
        repeat (40) begin
            r = $random(seed);
            req(r[2] ? {1'b1, r[6:3], 3'h0} : ids[int'(r[4:3]) % 3], r[7], r[8], r[9],
                r[12:10]);
        end
        $display("test random done");
        i_sfrid_core_model.idle();
        for (int n = 0; n < 10 && notes.size() > 0; n++) @(posedge i_mclk);
        if (notes.size() > 0) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, notes.size(), 0);
        end
        end_sim();
    end
endmodule : testbench
`default_nettype wire
